// File: core/mmx_pkg.sv
// Constants shared by the MIDI mixer control mapper
package mmx_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LINK = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;
    localparam logic [7:0] ADDR_DEVID = 8'h10;
    // Control fields and reset values
    localparam int CTRL_FMT = 0;
    localparam int CTRL_LOCAL = 2;
    localparam int CTRL_THRU = 3;
    localparam int CTRL_ROLE = 4;
    localparam int CMD_MMC_GO = 8;
    localparam int CMD_SCENE = 9;
    localparam logic [5:0] CTRL_RST = 6'h05;
    localparam logic [7:0] LINK_RST = 8'h00;
    localparam logic [6:0] DEVID_RST = 7'h10;
    // Format selector and machine-control role
    localparam logic [1:0] FMT_OFF = 2'h0;
    localparam logic [1:0] FMT_CC = 2'h1;
    localparam logic [1:0] FMT_EXCL = 2'h2;
    localparam logic [1:0] ROLE_OFF = 2'h0;
    localparam logic [1:0] ROLE_MASTER = 2'h1;
    localparam logic [1:0] ROLE_SLAVE = 2'h2;
    // Parameter groups
    localparam logic [1:0] GRP_TRACK = 2'h0;
    localparam logic [1:0] GRP_TRK17 = 2'h1;
    localparam logic [1:0] GRP_INPUT = 2'h2;
    localparam logic [1:0] GRP_MASTER = 2'h3;
    // Stream bytes
    localparam logic [3:0] ST_CC = 4'hb;
    localparam logic [7:0] SX_START = 8'hf0;
    localparam logic [7:0] SX_END = 8'hf7;
    localparam logic [7:0] QFRAME = 8'hf1;
    localparam logic [7:0] BEAT_CLK = 8'hf8;
    localparam logic [7:0] MMC_ALL = 8'h7f;
    localparam logic [7:0] MMC_SUB = 8'h06;
    // Receive states
    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_CC_NUM = 5'b00010,
        RX_CC_VAL = 5'b00100,
        RX_SYSEX = 5'b01000,
        RX_SKIP = 5'b10000
    } mmx_rx_e;
endpackage

// File: core/mmx_mapper.sv
// MIDI mixer control mapper with APB registers
// Behaviour
// - MIDI ch 1-16 map to tracks, ch 1-15 to inputs, ch16 to master; tracks 17/18 on ch1/2.
// - Linked pair is controlled only through the odd member's channel; panel fader moves on the even channel still go out on that channel.
// - Control changes on the even channel of a linked pair are dropped.
// - Tracks 1-16 use controllers 3, 7, 10 and 12-30.
// - Tracks 17/18 use controllers 35, 39, 42 and 44-62.
// - Input channels use controllers 68, 70 and 71-89.
// - Master uses 68, 70, 78-87, 102 and 103.
// - Mixer moves are both sent out and taken in as messages.
// - Format off: no mixer messages sent or acted upon.
// - Control Change format exchanges mixer control both ways.
// - Exclusive format exchanges mixer control by exclusive messages.
// - Local off: panel fader moves leave mixer levels unchanged.
// - Scene request during playback sends the whole mixer state.
// - Output connector role is selectable; mixer traffic uses output role.
// - Master sends transport commands; slave's sync returns to master.
// - Machine-control messages carry no timing; sync comes separately.
// - Machine-control role is master, slave or off.
//
// Our own choices: the APB slave port and the address map.
module mmx_mapper #(
    parameter logic [7:0] SX_ID = 8'h7d, // Arbitrary exclusive tag
    parameter int MSG_MAX = 6
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // MIDI byte streams
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    input wire logic tx_ready,
    // Panel faders and transport
    input wire logic fader_valid,
    input wire logic [3:0] fader_chan,
    input wire logic [6:0] fader_ctrl,
    input wire logic [6:0] fader_value,
    output logic fader_ready,
    input wire logic play_active,
    // Mixer parameter updates
    output logic param_valid,
    output logic [1:0] param_group,
    output logic [3:0] param_chan,
    output logic [6:0] param_ctrl,
    output logic [6:0] param_value,
    // Received transport commands
    output logic mmc_cmd_valid,
    output logic [7:0] mmc_cmd
);
    import mmx_pkg::*;

    // Refuse a message length that cannot hold an exclusive frame
    if (MSG_MAX < 6) begin : g_size_chk
        $error("MSG_MAX must hold an exclusive message");
    end

    // Group lookup; bit 2 flags a mapped pair
    function automatic logic [2:0] map_cc(input logic [3:0] ch, input logic [6:0] cc);
        logic trk;
        logic t17;
        logic inp;
        logic mst;
        trk = cc == 7'd3 || cc == 7'd7 || cc == 7'd10 || (cc >= 7'd12 && cc <= 7'd30);
        t17 = ch <= 4'd1 && (cc == 7'd35 || cc == 7'd39 || cc == 7'd42
            || (cc >= 7'd44 && cc <= 7'd62));
        inp = ch <= 4'd14 && (cc == 7'd68 || (cc >= 7'd70 && cc <= 7'd89));
        mst = ch == 4'd15 && (cc == 7'd68 || cc == 7'd70 || (cc >= 7'd78 && cc <= 7'd87)
            || cc == 7'd102 || cc == 7'd103);
        if (trk) map_cc = {1'b1, GRP_TRACK};
        else if (t17) map_cc = {1'b1, GRP_TRK17};
        else if (inp) map_cc = {1'b1, GRP_INPUT};
        else if (mst) map_cc = {1'b1, GRP_MASTER};
        else map_cc = 3'h0;
    endfunction

    // Outgoing mixer message, length in top bits
    function automatic logic [50:0] mk_msg(input logic [1:0] fmt, input logic [3:0] ch,
                                           input logic [6:0] cc, input logic [6:0] v);
        if (fmt == FMT_EXCL)
            mk_msg = {3'd6, SX_START, SX_ID, 4'h0, ch, 1'b0, cc, 1'b0, v, SX_END};
        else
            mk_msg = {3'd3, ST_CC, ch, 1'b0, cc, 1'b0, v, 24'h0};
    endfunction

    logic [5:0] ctrl_reg;
    logic [7:0] link_reg;
    logic [6:0] devid_reg;
    logic sync_reg;
    mmx_rx_e rx_st;
    logic [3:0] rx_ch;
    logic [6:0] rx_cc;
    logic [7:0] sx_buf [0:3];
    logic [2:0] sx_cnt;
    logic ev_valid, ev_sx;
    logic [3:0] ev_ch;
    logic [6:0] ev_cc, ev_val;
    logic fd_pend;
    logic [3:0] fd_ch;
    logic [6:0] fd_cc, fd_val;
    logic mmc_pend;
    logic [7:0] mmc_go;
    logic scan_on;
    logic [10:0] scan_addr;
    logic busy;
    logic [47:0] msg_reg;
    logic [2:0] len_reg, idx_reg;
    logic [6:0] mem [0:2047];

    // Control fields
    wire [1:0] fmt = ctrl_reg[CTRL_FMT +: 2];
    wire local_on = ctrl_reg[CTRL_LOCAL];
    wire thru = ctrl_reg[CTRL_THRU];
    wire [1:0] role = ctrl_reg[CTRL_ROLE +: 2];

    // APB decode; writes land on the edge that sees pready
    wire apb_acc = psel && penable && !pready;
    wire wr_fire = psel && penable && pready && pwrite;
    wire hit = paddr == ADDR_CTRL || paddr == ADDR_LINK || paddr == ADDR_CMD
        || paddr == ADDR_STAT || paddr == ADDR_DEVID;
    wire [31:0] rd_mux = paddr == ADDR_CTRL ? {26'h0, ctrl_reg}
        : paddr == ADDR_LINK ? {24'h0, link_reg}
        : paddr == ADDR_STAT ? {27'h0, fd_pend, scan_on, mmc_pend, busy, sync_reg}
        : paddr == ADDR_DEVID ? {25'h0, devid_reg} : 32'h0;
    wire cmd_wr = wr_fire && paddr == ADDR_CMD;

    // Receive classification
    wire rx_rt = rx_valid && rx_byte >= BEAT_CLK;
    wire rx_stat = rx_valid && rx_byte[7] && !rx_rt;
    wire rx_data = rx_valid && !rx_byte[7];
    wire sx_done = rx_stat && rx_byte == SX_END && rx_st == RX_SYSEX && sx_cnt == 3'd4;
    wire mmc_hit = sx_buf[0] == MMC_ALL && sx_buf[2] == MMC_SUB
        && (sx_buf[1] == MMC_ALL || sx_buf[1] == {1'b0, devid_reg});
    // Only beat clock or time code counts as sync, never a command
    wire sync_evt = role == ROLE_MASTER && (rx_rt && rx_byte == BEAT_CLK
        || rx_stat && rx_byte == QFRAME);

    // Apply stage
    wire [2:0] ev_map = map_cc(ev_ch, ev_cc);
    wire ev_fmt_ok = ev_sx ? fmt == FMT_EXCL : fmt == FMT_CC;
    wire linked_even = link_reg[ev_ch[3:1]] && ev_ch[0];
    wire rx_apply = ev_valid && ev_fmt_ok && ev_map[2] && !linked_even;
    wire [2:0] fd_map = map_cc(fd_ch, fd_cc);
    wire tx_free = !tx_valid || tx_ready;
    wire fd_take = fd_pend && !ev_valid && !busy && !mmc_pend;
    wire fd_apply = fd_take && local_on && fd_map[2];
    wire fd_send = fd_take && fmt != FMT_OFF && !thru && fd_map[2];
    wire [10:0] mem_wa = rx_apply ? {ev_ch, ev_cc} : {fd_ch, fd_cc};
    wire [2:0] scan_map = map_cc(scan_addr[10:7], scan_addr[6:0]);
    wire scan_step = scan_on && !busy && !mmc_pend && !fd_take;
    wire fd_pend_next = fader_valid && fader_ready ? 1'b1 : fd_take ? 1'b0 : fd_pend;
    wire [50:0] fd_msg = mk_msg(fmt, fd_ch, fd_cc, fd_val);
    wire [50:0] sc_msg = mk_msg(fmt, scan_addr[10:7], scan_addr[6:0], mem[scan_addr]);

    // APB slave, one wait state
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_acc;
            if (apb_acc) begin
                prdata <= pwrite ? 32'h0 : rd_mux;
                pslverr <= !hit;
            end
        end
    end

    // Configuration registers; sync sticky set beats clear
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ctrl_reg <= CTRL_RST;
            link_reg <= LINK_RST;
            devid_reg <= DEVID_RST;
            sync_reg <= 1'b0;
        end else begin
            if (wr_fire && paddr == ADDR_CTRL) ctrl_reg <= pwdata[5:0];
            if (wr_fire && paddr == ADDR_LINK) link_reg <= pwdata[7:0];
            if (wr_fire && paddr == ADDR_DEVID) devid_reg <= pwdata[6:0];
            if (sync_evt) sync_reg <= 1'b1;
            else if (wr_fire && paddr == ADDR_STAT && pwdata[0]) sync_reg <= 1'b0;
        end
    end

    // Receive parser with running status
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rx_st <= RX_IDLE;
            rx_ch <= 4'h0;
            rx_cc <= 7'h0;
            sx_cnt <= 3'h0;
            ev_valid <= 1'b0;
            ev_sx <= 1'b0;
            ev_ch <= 4'h0;
            ev_cc <= 7'h0;
            ev_val <= 7'h0;
            mmc_cmd_valid <= 1'b0;
            mmc_cmd <= 8'h0;
        end else begin
            ev_valid <= 1'b0;
            mmc_cmd_valid <= 1'b0;
            if (rx_stat) begin
                rx_st <= RX_IDLE;
                if (rx_byte[7:4] == ST_CC) begin
                    rx_st <= RX_CC_NUM;
                    rx_ch <= rx_byte[3:0];
                end else if (rx_byte == SX_START) begin
                    rx_st <= RX_SYSEX;
                    sx_cnt <= 3'h0;
                end else if (rx_byte == QFRAME) begin
                    rx_st <= RX_SKIP;
                end
                if (sx_done && sx_buf[0] == SX_ID) begin
                    ev_valid <= 1'b1;
                    ev_sx <= 1'b1;
                    ev_ch <= sx_buf[1][3:0];
                    ev_cc <= sx_buf[2][6:0];
                    ev_val <= sx_buf[3][6:0];
                end
                if (sx_done && mmc_hit && role == ROLE_SLAVE) begin
                    mmc_cmd_valid <= 1'b1;
                    mmc_cmd <= sx_buf[3];
                end
            end else if (rx_data) begin
                unique case (rx_st)
                    RX_IDLE: rx_st <= RX_IDLE;
                    RX_CC_NUM: begin
                        rx_cc <= rx_byte[6:0];
                        rx_st <= RX_CC_VAL;
                    end
                    RX_CC_VAL: begin
                        ev_valid <= 1'b1;
                        ev_sx <= 1'b0;
                        ev_ch <= rx_ch;
                        ev_cc <= rx_cc;
                        ev_val <= rx_byte[6:0];
                        rx_st <= RX_CC_NUM;
                    end
                    RX_SYSEX: begin
                        if (sx_cnt < 3'd4) sx_buf[sx_cnt[1:0]] <= rx_byte;
                        if (sx_cnt < 3'd5) sx_cnt <= sx_cnt + 3'd1;
                    end
                    RX_SKIP: rx_st <= RX_IDLE;
                endcase
            end
        end
    end

    // Parameter updates and state memory
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            param_valid <= 1'b0;
            param_group <= 2'h0;
            param_chan <= 4'h0;
            param_ctrl <= 7'h0;
            param_value <= 7'h0;
        end else begin
            param_valid <= rx_apply || fd_apply;
            if (rx_apply) begin
                param_group <= ev_map[1:0];
                param_chan <= ev_ch;
                param_ctrl <= ev_cc;
                param_value <= ev_val;
            end else if (fd_apply) begin
                param_group <= fd_map[1:0];
                param_chan <= fd_ch;
                param_ctrl <= fd_cc;
                param_value <= fd_val;
            end
        end
    end

    // Memory has no reset; it only feeds the scene walk
    always_ff @(posedge clk_sys) begin
        if (rx_apply || fd_apply) mem[mem_wa] <= rx_apply ? ev_val : fd_val;
    end

    // Fader holding slot and command requests
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            fd_pend <= 1'b0;
            fader_ready <= 1'b0;
            fd_ch <= 4'h0;
            fd_cc <= 7'h0;
            fd_val <= 7'h0;
            mmc_pend <= 1'b0;
            mmc_go <= 8'h0;
            scan_on <= 1'b0;
            scan_addr <= 11'h0;
        end else begin
            fd_pend <= fd_pend_next;
            fader_ready <= !fd_pend_next;
            if (fader_valid && fader_ready) begin
                fd_ch <= fader_chan;
                fd_cc <= fader_ctrl;
                fd_val <= fader_value;
            end
            if (cmd_wr && pwdata[CMD_MMC_GO] && role == ROLE_MASTER) begin
                mmc_pend <= 1'b1;
                mmc_go <= pwdata[7:0];
            end else if (mmc_pend && !busy) begin
                mmc_pend <= 1'b0;
            end
            // Snapshot only while playing and mixer traffic is enabled
            if (cmd_wr && pwdata[CMD_SCENE] && play_active && fmt != FMT_OFF && !thru) begin
                scan_on <= 1'b1;
                scan_addr <= 11'h0;
            end else if (scan_step) begin
                scan_addr <= scan_addr + 11'd1;
                if (scan_addr == 11'h7ff) scan_on <= 1'b0;
            end
        end
    end

    // Transmit sequencer; thru role bypasses mixer traffic
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            tx_valid <= 1'b0;
            tx_byte <= 8'h0;
            busy <= 1'b0;
            msg_reg <= 48'h0;
            len_reg <= 3'h0;
            idx_reg <= 3'h0;
        end else begin
            if (tx_valid && tx_ready) tx_valid <= 1'b0;
            if (thru) begin
                // Bytes arriving while the output stalls are lost
                if (rx_valid && tx_free) begin
                    tx_valid <= 1'b1;
                    tx_byte <= rx_byte;
                end
            end else if (busy) begin
                if (tx_free) begin
                    tx_valid <= 1'b1;
                    tx_byte <= msg_reg[47 - 8 * idx_reg -: 8];
                    idx_reg <= idx_reg + 3'd1;
                    if (idx_reg == len_reg - 3'd1) busy <= 1'b0;
                end
            end else if (mmc_pend) begin
                busy <= 1'b1;
                idx_reg <= 3'h0;
                len_reg <= 3'd6;
                msg_reg <= {SX_START, MMC_ALL, 1'b0, devid_reg, MMC_SUB, mmc_go, SX_END};
            end else if (fd_send) begin
                busy <= 1'b1;
                idx_reg <= 3'h0;
                {len_reg, msg_reg} <= fd_msg;
            end else if (scan_step && scan_map[2]) begin
                busy <= 1'b1;
                idx_reg <= 3'h0;
                {len_reg, msg_reg} <= sc_msg;
            end
        end
    end

    // Checks
    link_drop_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ev_valid && linked_even |=> !param_valid) else $error("linked even channel applied");
    fmt_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ev_valid && fmt == FMT_OFF |=> !param_valid) else $error("applied with format off");
    cc_apply_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ev_valid && !ev_sx && fmt == FMT_CC && ev_map[2] && !linked_even
        |=> param_valid && param_value == $past(ev_val)) else $error("cc not applied");
    excl_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ev_valid && ev_sx && fmt != FMT_EXCL |=> !param_valid) else $error("excl in wrong fmt");
    local_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        fd_take && !local_on |=> !param_valid) else $error("fader moved level");
    unmapped_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ev_valid && !ev_map[2] |=> !param_valid) else $error("unmapped pair applied");
    thru_echo_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        thru && rx_valid && tx_free |=> tx_valid && tx_byte == $past(rx_byte))
        else $error("thru byte lost");
    sync_seen_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        role == ROLE_MASTER && rx_valid && rx_byte == BEAT_CLK |=> sync_reg)
        else $error("sync not flagged");
    slave_cmd_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        mmc_cmd_valid |-> $past(role) == ROLE_SLAVE) else $error("command outside slave role");
    apb_wait_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        apb_acc |=> pready ##1 !pready) else $error("apb answer timing");
endmodule

// File: tb/mmx_midi_peer.sv
// Behavioural MIDI controller and sequencer facing the mapper's byte streams
module mmx_midi_peer (
    // Clock
    input wire logic clk_sys,
    // Stream into the device
    output logic rx_valid,
    output logic [7:0] rx_byte,
    // Stream out of the device
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    output logic tx_ready,
    // Stall control
    input wire logic slow
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        tx_ready = 1'b0;
    end
    // One byte per slot; idle line shows the inverse so stale data never matches
    task automatic send(input logic [7:0] b);
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_byte <= b;
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_byte <= ~b;
    endtask
    // Slow mode stalls every other cycle to stretch the output handshake
    always @(posedge clk_sys) tx_ready <= slow ? ~tx_ready : 1'b1;
    // Record the outgoing stream; nothing is echoed back, avoiding a loop
    always @(posedge clk_sys) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_byte);
    end
endmodule

// File: tb/tb_top.sv
// Self-checking testbench for the MIDI mixer control mapper
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mmx_pkg::*;
    logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, er, slow;
    logic rx_valid, tx_valid, tx_ready, fader_valid, fader_ready, play_active;
    logic param_valid, mmc_cmd_valid;
    logic [7:0] paddr, rx_byte, tx_byte, mmc_cmd;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] fader_chan, param_chan;
    logic [6:0] fader_ctrl, fader_value, param_ctrl, param_value;
    logic [1:0] param_group;
    logic [19:0] pq[$];
    logic [7:0] mq[$];
    int err_total = 0;
    int n_tests = 0;
    // Channel, controller, group and hit flag for the mapping table
    logic [3:0] t_ch[7] = '{4'h0, 4'h0, 4'ha, 4'hf, 4'hf, 4'hf, 4'h0};
    logic [6:0] t_cc[7] = '{7'h07, 7'h23, 7'h44, 7'h66, 7'h47, 7'h1e, 7'h1f};
    logic [1:0] t_gr[7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0};
    logic t_hit[7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

    mmx_mapper uut (
        .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_ready(tx_ready), .fader_valid(fader_valid), .fader_chan(fader_chan),
        .fader_ctrl(fader_ctrl), .fader_value(fader_value), .fader_ready(fader_ready),
        .play_active(play_active), .param_valid(param_valid), .param_group(param_group),
        .param_chan(param_chan), .param_ctrl(param_ctrl), .param_value(param_value),
        .mmc_cmd_valid(mmc_cmd_valid), .mmc_cmd(mmc_cmd)
    );
    mmx_midi_peer peer (
        .clk_sys(clk_sys), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_ready(tx_ready), .slow(slow)
    );

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Collect one-cycle pulses so short outputs are never missed
    always @(posedge clk_sys) begin
        if (param_valid === 1'b1) pq.push_back({param_group, param_chan, param_ctrl, param_value});
        if (mmc_cmd_valid === 1'b1) mq.push_back(mmc_cmd);
    end

    task automatic final_report();
        $display("Checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic hang(input string what);
        err_total++;
        $display("FAIL %0t timeout %s", $time, what);
        final_report();
    endtask
    // One APB transfer; waits for pready with a bound, never assumes latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
            if (k > 50) hang("apb");
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_tx(input int n);
        int k;
        for (k = 0; k < 3000 && peer.got.size() < n; k++) @(posedge clk_sys);
        if (k == 3000) hang("tx");
    endtask
    task automatic cc(input logic [3:0] ch, input logic [6:0] num, input logic [6:0] v);
        pq.delete();
        peer.send({ST_CC, ch});
        peer.send({1'b0, num});
        peer.send({1'b0, v});
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic exp_par(input logic hit, input logic [19:0] e);
        chk(pq.size(), {31'h0, hit}, "param count");
        if (hit && pq.size() > 0) chk({12'h0, pq[0]}, {12'h0, e}, "param fields");
    endtask
    task automatic sx(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3,
                      input logic [7:0] b4);
        pq.delete();
        mq.delete();
        peer.send(SX_START);
        peer.send(b1);
        peer.send(b2);
        peer.send(b3);
        peer.send(b4);
        peer.send(SX_END);
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic fader(input logic [3:0] ch, input logic [6:0] c, input logic [6:0] v);
        int k;
        k = 0;
        pq.delete();
        peer.got.delete();
        @(posedge clk_sys);
        fader_valid <= 1'b1;
        fader_chan <= ch;
        fader_ctrl <= c;
        fader_value <= v;
        do begin
            @(posedge clk_sys);
            k++;
        end while (fader_ready !== 1'b1 && k < 100);
        if (fader_ready !== 1'b1) hang("fader");
        fader_valid <= 1'b0;
        wait_tx(3);
        repeat (4) @(posedge clk_sys);
    endtask

    // Main sequence
    initial begin
        int i;
        {resetn, psel, penable, pwrite, fader_valid, play_active, slow} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        {fader_chan, fader_ctrl, fader_value} = 18'h0;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        // Reset values and an unmapped address
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, {26'h0, CTRL_RST}, "ctrl reset");
        apb(1'b0, ADDR_DEVID, 32'h0);
        chk(rd, {25'h0, DEVID_RST}, "devid reset");
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped err");
        $display("test registers done");
        // Channel and controller mapping
        for (i = 0; i < 7; i++) begin
            cc(t_ch[i], t_cc[i], 7'h40 + 7'(i));
            exp_par(t_hit[i], {t_gr[i], t_ch[i], t_cc[i], 7'h40 + 7'(i)});
        end
        $display("test mapping done");
        // Linked pair: only the odd member's channel controls
        apb(1'b1, ADDR_LINK, 32'h1);
        cc(4'h1, 7'h07, 7'h11);
        exp_par(1'b0, 20'h0);
        cc(4'h0, 7'h07, 7'h12);
        exp_par(1'b1, {GRP_TRACK, 4'h0, 7'h07, 7'h12});
        apb(1'b1, ADDR_LINK, 32'h0);
        $display("test link done");
        // Format selector: exclusive refused in CC, then off, then exclusive
        sx(8'h7d, 8'h03, 8'h07, 8'h56);
        exp_par(1'b0, 20'h0);
        apb(1'b1, ADDR_CTRL, 32'h04);
        cc(4'h0, 7'h07, 7'h13);
        exp_par(1'b0, 20'h0);
        apb(1'b1, ADDR_CTRL, 32'h06);
        cc(4'h0, 7'h07, 7'h14);
        exp_par(1'b0, 20'h0);
        sx(8'h7d, 8'h03, 8'h07, 8'h55); // Tag matches the design's default exclusive tag
        exp_par(1'b1, {GRP_TRACK, 4'h3, 7'h07, 7'h55});
        fader(4'h3, 7'h07, 7'h24);
        chk({peer.got[0], peer.got[1], peer.got[5]}, 32'hf07df7, "excl bytes");
        $display("test format done");
        // Panel fader goes out as a message, with the local switch on and off
        apb(1'b1, ADDR_CTRL, 32'h05);
        slow <= 1'b1;
        fader(4'h3, 7'h07, 7'h22);
        chk({peer.got[0], peer.got[1], peer.got[2]}, 32'hb30722, "fader bytes");
        exp_par(1'b1, {GRP_TRACK, 4'h3, 7'h07, 7'h22});
        apb(1'b1, ADDR_CTRL, 32'h01);
        fader(4'h3, 7'h07, 7'h23);
        exp_par(1'b0, 20'h0);
        slow <= 1'b0;
        $display("test fader done");
        // Machine control reception in each role; only slave acts
        for (i = 0; i < 3; i++) begin
            apb(1'b1, ADDR_CTRL, 32'h05 | (i << 4));
            sx(MMC_ALL, {1'b0, DEVID_RST}, MMC_SUB, 8'h02);
            chk(mq.size(), (i == 2) ? 1 : 0, "mmc rx count");
        end
        if (mq.size() > 0) chk(mq[0], 32'h02, "mmc rx cmd");
        // Master role sends the transport command and sees the returned sync
        apb(1'b1, ADDR_CTRL, 32'h15);
        peer.got.delete();
        apb(1'b1, ADDR_CMD, 32'h102);
        wait_tx(6);
        chk({peer.got[0], peer.got[3], peer.got[4], peer.got[5]}, 32'hf00602f7, "mmc tx");
        mq.delete();
        peer.send(BEAT_CLK);
        repeat (4) @(posedge clk_sys);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk({31'h0, rd[0]}, 32'h1, "sync seen");
        chk(mq.size(), 32'h0, "sync is no cmd");
        apb(1'b1, ADDR_STAT, 32'h1);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk({31'h0, rd[0]}, 32'h0, "sync cleared");
        $display("test machine control done");
        // Scene snapshot refused when stopped or in thru role, runs in playback
        apb(1'b1, ADDR_CTRL, 32'h05);
        apb(1'b1, ADDR_CMD, 32'h200);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk({31'h0, rd[3]}, 32'h0, "scene stopped");
        play_active <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h0d);
        apb(1'b1, ADDR_CMD, 32'h200);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk({31'h0, rd[3]}, 32'h0, "scene thru");
        peer.got.delete();
        peer.send(8'h45);
        repeat (4) @(posedge clk_sys);
        chk({24'h0, peer.got[0]}, 32'h45, "thru echo");
        apb(1'b1, ADDR_CTRL, 32'h05);
        peer.got.delete();
        apb(1'b1, ADDR_CMD, 32'h200);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk({31'h0, rd[3]}, 32'h1, "scene runs");
        for (i = 0; i < 6000 && rd[3] !== 1'b0; i++) apb(1'b0, ADDR_STAT, 32'h0);
        if (i == 6000) hang("scene");
        chk({28'h0, peer.got[0][7:4]}, {28'h0, ST_CC}, "scene bytes");
        $display("test scene done");
        final_report();
    end
endmodule
